/* hw/scu_cfg_regs.svh */
// register offsets, field positions, reset values and serial frame counts
`ifndef SCU_CFG_REGS_SVH
`define SCU_CFG_REGS_SVH

// ---------------------------------------------------------------
// serial configuration addresses
// ---------------------------------------------------------------
`define SCU_ADDR_CLOCK_GEN    9'h020
`define SCU_ADDR_PIXEL_ARRAY  9'h028
`define SCU_ADDR_FRONT_END    9'h030
`define SCU_ADDR_BIAS_LO      9'h040
`define SCU_ADDR_BIAS_HI      9'h047
`define SCU_ADDR_SERIAL_OUT   9'h070
`define SCU_ADDR_BLACK_LO     9'h080
`define SCU_ADDR_BLACK_HI     9'h087
`define SCU_ADDR_TEST_LO      9'h090
`define SCU_ADDR_TEST_HI      9'h096
`define SCU_ADDR_SEQ_CTRL     9'h0c0
`define SCU_ADDR_WINDOW_SEL   9'h0c3
`define SCU_ADDR_DARK_LINES   9'h0c5
`define SCU_ADDR_FILLER_LINES 9'h0c6
`define SCU_ADDR_EXPOSURE_LO  9'h0c7
`define SCU_ADDR_EXPOSURE_HI  9'h0cb
`define SCU_ADDR_GAIN         9'h0cc
`define SCU_ADDR_SYNC_CFG     9'h0ce
`define SCU_ADDR_GEOM_LO      9'h100
`define SCU_ADDR_GEOM_HI      9'h117

// ---------------------------------------------------------------
// storage indices
// ---------------------------------------------------------------
`define SCU_NREG              62
`define SCU_IDX_CLOCK_GEN     6'h00
`define SCU_IDX_PIXEL_ARRAY   6'h01
`define SCU_IDX_FRONT_END     6'h02
`define SCU_IDX_BIAS          6'h03
`define SCU_IDX_SERIAL_OUT    6'h0b
`define SCU_IDX_BLACK         6'h0c
`define SCU_IDX_TEST          6'h14
`define SCU_IDX_SEQ_CTRL      6'h1b
`define SCU_IDX_WINDOW_SEL    6'h1c
`define SCU_IDX_DARK_LINES    6'h1d
`define SCU_IDX_FILLER_LINES  6'h1e
`define SCU_IDX_EXPOSURE      6'h1f
`define SCU_IDX_EXPOSURE_TOP  6'h23
`define SCU_IDX_GAIN          6'h24
`define SCU_IDX_SYNC_CFG      6'h25
`define SCU_IDX_GEOM          6'h26

// ---------------------------------------------------------------
// field positions and reset value
// ---------------------------------------------------------------
`define SCU_SEQ_ENABLE_BIT    0
`define SCU_SEQ_ROLLING_BIT   1
`define SCU_SEQ_TRIGGER_BIT   4
`define SCU_SEQ_FOLLOWER_BIT  5
`define SCU_SEQ_SUBSAMPLE_BIT 7
`define SCU_SEQ_BINNING_BIT   8
`define SCU_SEQ_EXP_IMM_BIT   10
`define SCU_EXP_GAIN_LAT_BIT  13
`define SCU_SYNC_BLANK_WIN_BIT 8
`define SCU_RESET_WORD        16'h0000

// ---------------------------------------------------------------
// serial frame: 9 address bits, 1 write bit, 16 data bits
// ---------------------------------------------------------------
`define SCU_SPI_ADDR_BITS     5'h09
`define SCU_SPI_LAST_BIT      5'h19

`endif

/* hw/scu_pkg.sv */
// types shared by the configuration update block
package scu_pkg;

   typedef logic [15:0] scu_word_t;

   typedef struct packed {
      logic                 subsample;
      logic                 binning;
      scu_word_t            window;
      scu_word_t            dark_lines;
      scu_word_t            filler_lines;
      logic [4:0][15:0]     exposure;
      scu_word_t            gain;
   } scu_active_t;

   typedef enum logic [2:0] {
      SCU_IDLE  = 3'b001,
      SCU_SHIFT = 3'b010,
      SCU_HOLD  = 3'b100
   } scu_spi_st_t;

endpackage

/* hw/scu_cfg_update.sv */
// serial-programmed configuration store with frame-synchronised active copies
`timescale 1ns/100ps
`include "scu_cfg_regs.svh"

// Notes on behaviour
// - black-level writes apply at once; a few frames may be miscompensated
// - sync code writes apply at once; that frame may carry wrong codes
// - test pattern writes apply at once; one frame may show wrong patterns
// - artifact-prone writes take effect without stopping acquisition
// - frame parameters change only at a frame start, never mid-frame
// - a blanked frame sends training patterns instead of image data
// - subsampling and binning bits apply at the next frame start
// - dark or filler line change blanks one frame in rolling mode only
// - rolling mode window switch blanks one frame only if blanking bit set
// - a window switch means the selection register now selects another window
// - resizing the active window never blanks a frame
// - exposure applies one frame late, except triggered master with immediate bit
// - gain applies at the next frame start
// - gain alignment bit delays gain by one more frame to match exposure
module scu_cfg_update (
   // clock, reset, enable
   input  wire logic                        clock,
   input  wire logic                        resetn,
   input  wire logic                        clk_en,
   // serial configuration port
   input  wire logic                        spi_sck,
   input  wire logic                        spi_cs_n,
   input  wire logic                        spi_mosi,
   output      logic                        spi_miso,
   output      logic                        spi_miso_oe,
   // sequencer side
   input  wire logic                        frame_start,
   output      scu_pkg::scu_word_t [`SCU_NREG-1:0] live_cfg,
   output      scu_pkg::scu_active_t        active_cfg,
   output      logic                        send_training
);

   // ---------------------------------------------------------------
   // reset release and pin synchronisers
   // ---------------------------------------------------------------
   logic                rst_meta_q;
   logic                rst_n;
   logic [2:0]          pin_meta_q;
   logic [2:0]          pin_sync_q;
   logic                sck_prev_q;
   logic                sck_s;
   logic                cs_n_s;
   logic                mosi_s;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= 3'h2;
         pin_sync_q <= 3'h2;
         sck_prev_q <= 1'b0;
      end else if (clk_en) begin
         pin_meta_q <= {spi_mosi, spi_cs_n, spi_sck};
         pin_sync_q <= pin_meta_q;
         sck_prev_q <= pin_sync_q[0];
      end
   end

   assign sck_s  = pin_sync_q[0];
   assign cs_n_s = pin_sync_q[1];
   assign mosi_s = pin_sync_q[2];

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic logic [6:0] map_idx(input logic [8:0] a);
      map_idx = 7'h00;
      if (a == `SCU_ADDR_CLOCK_GEN) map_idx = {1'b1, `SCU_IDX_CLOCK_GEN};
      else if (a == `SCU_ADDR_PIXEL_ARRAY) map_idx = {1'b1, `SCU_IDX_PIXEL_ARRAY};
      else if (a == `SCU_ADDR_FRONT_END) map_idx = {1'b1, `SCU_IDX_FRONT_END};
      else if (a >= `SCU_ADDR_BIAS_LO && a <= `SCU_ADDR_BIAS_HI)
         map_idx = {1'b1, 6'(a - `SCU_ADDR_BIAS_LO + 9'(`SCU_IDX_BIAS))};
      else if (a == `SCU_ADDR_SERIAL_OUT) map_idx = {1'b1, `SCU_IDX_SERIAL_OUT};
      else if (a >= `SCU_ADDR_BLACK_LO && a <= `SCU_ADDR_BLACK_HI)
         map_idx = {1'b1, 6'(a - `SCU_ADDR_BLACK_LO + 9'(`SCU_IDX_BLACK))};
      else if (a >= `SCU_ADDR_TEST_LO && a <= `SCU_ADDR_TEST_HI)
         map_idx = {1'b1, 6'(a - `SCU_ADDR_TEST_LO + 9'(`SCU_IDX_TEST))};
      else if (a == `SCU_ADDR_SEQ_CTRL) map_idx = {1'b1, `SCU_IDX_SEQ_CTRL};
      else if (a == `SCU_ADDR_WINDOW_SEL) map_idx = {1'b1, `SCU_IDX_WINDOW_SEL};
      else if (a == `SCU_ADDR_DARK_LINES) map_idx = {1'b1, `SCU_IDX_DARK_LINES};
      else if (a == `SCU_ADDR_FILLER_LINES) map_idx = {1'b1, `SCU_IDX_FILLER_LINES};
      else if (a >= `SCU_ADDR_EXPOSURE_LO && a <= `SCU_ADDR_EXPOSURE_HI)
         map_idx = {1'b1, 6'(a - `SCU_ADDR_EXPOSURE_LO + 9'(`SCU_IDX_EXPOSURE))};
      else if (a == `SCU_ADDR_GAIN) map_idx = {1'b1, `SCU_IDX_GAIN};
      else if (a == `SCU_ADDR_SYNC_CFG) map_idx = {1'b1, `SCU_IDX_SYNC_CFG};
      else if (a >= `SCU_ADDR_GEOM_LO && a <= `SCU_ADDR_GEOM_HI)
         map_idx = {1'b1, 6'(a - `SCU_ADDR_GEOM_LO + 9'(`SCU_IDX_GEOM))};
   endfunction

   // ---------------------------------------------------------------
   // serial port shifter
   // ---------------------------------------------------------------
   scu_pkg::scu_spi_st_t          st_q, st_d;
   logic [4:0]                    cnt_q, cnt_d;
   logic [25:0]                   sh_q, sh_d;
   logic [15:0]                   out_q, out_d;
   logic                          miso_q, miso_d;
   logic                          oe_q, oe_d;
   logic                          wr_q, wr_d;
   scu_pkg::scu_word_t [`SCU_NREG-1:0] reg_q, reg_d;
   logic [6:0]                    rd_map;
   logic [6:0]                    wr_map;
   logic                          sck_rise;
   logic                          sck_fall;

   assign sck_rise = sck_s & ~sck_prev_q;
   assign sck_fall = ~sck_s & sck_prev_q;
   assign rd_map   = map_idx(sh_q[8:0]);
   assign wr_map   = map_idx(sh_q[25:17]);

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      sh_d   = sh_q;
      out_d  = out_q;
      miso_d = miso_q;
      oe_d   = oe_q;
      wr_d   = 1'b0;
      if (cs_n_s) begin
         st_d   = scu_pkg::SCU_IDLE;
         cnt_d  = 5'h00;
         oe_d   = 1'b0;
         miso_d = 1'b0;
      end else begin
         unique case (st_q)
            scu_pkg::SCU_IDLE: begin
               st_d  = scu_pkg::SCU_SHIFT;
               cnt_d = 5'h00;
               oe_d  = 1'b1;
            end
            scu_pkg::SCU_SHIFT: begin
               if (sck_rise) begin
                  sh_d  = {sh_q[24:0], mosi_s};
                  cnt_d = cnt_q + 5'h01;
                  if (cnt_q == `SCU_SPI_ADDR_BITS) begin
                     out_d = rd_map[6] ? reg_q[rd_map[5:0]] : 16'h0000;
                  end
                  if (cnt_q == `SCU_SPI_LAST_BIT) begin
                     st_d = scu_pkg::SCU_HOLD;
                     wr_d = sh_q[15];
                  end
               end
               if (sck_fall) begin
                  miso_d = out_q[15];
                  out_d  = {out_q[14:0], 1'b0};
               end
            end
            scu_pkg::SCU_HOLD: begin
               st_d = scu_pkg::SCU_HOLD;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q   <= scu_pkg::SCU_IDLE;
         cnt_q  <= 5'h00;
         sh_q   <= 26'h0000000;
         out_q  <= 16'h0000;
         miso_q <= 1'b0;
         oe_q   <= 1'b0;
         wr_q   <= 1'b0;
      end else if (clk_en) begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         sh_q   <= sh_d;
         out_q  <= out_d;
         miso_q <= miso_d;
         oe_q   <= oe_d;
         wr_q   <= wr_d;
      end
   end

   // ---------------------------------------------------------------
   // live register store
   // ---------------------------------------------------------------
   // static and artifact-prone groups act straight from here, so a
   // write never halts the sequencer; dynamic ones wait as pending
   always_comb begin
      reg_d = reg_q;
      if (wr_q && wr_map[6]) begin
         reg_d[wr_map[5:0]] = sh_q[15:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_q <= {`SCU_NREG{`SCU_RESET_WORD}};
      end else if (clk_en) begin
         reg_q <= reg_d;
      end
   end

   // ---------------------------------------------------------------
   // frame-synchronised active copies
   // ---------------------------------------------------------------
   scu_pkg::scu_active_t   act_q, act_d;
   logic [4:0][15:0]       exp_stg_q, exp_stg_d;
   scu_pkg::scu_word_t     gain_stg_q, gain_stg_d;
   logic                   blank_q, blank_d;
   logic [4:0][15:0]       exp_pend;
   logic                   rolling;
   logic                   exp_now;
   logic                   gain_late;
   logic                   win_switch;
   logic                   lines_chg;

   assign exp_pend   = reg_q[`SCU_IDX_EXPOSURE_TOP:`SCU_IDX_EXPOSURE];
   assign rolling    = reg_q[`SCU_IDX_SEQ_CTRL][`SCU_SEQ_ROLLING_BIT];
   assign exp_now    = reg_q[`SCU_IDX_SEQ_CTRL][`SCU_SEQ_TRIGGER_BIT]
                     & ~reg_q[`SCU_IDX_SEQ_CTRL][`SCU_SEQ_FOLLOWER_BIT]
                     & reg_q[`SCU_IDX_SEQ_CTRL][`SCU_SEQ_EXP_IMM_BIT];
   assign gain_late  = reg_q[`SCU_IDX_EXPOSURE][`SCU_EXP_GAIN_LAT_BIT];
   assign win_switch = reg_q[`SCU_IDX_WINDOW_SEL] != act_q.window;
   assign lines_chg  = (reg_q[`SCU_IDX_DARK_LINES] != act_q.dark_lines)
                     | (reg_q[`SCU_IDX_FILLER_LINES] != act_q.filler_lines);

   always_comb begin
      act_d      = act_q;
      exp_stg_d  = exp_stg_q;
      gain_stg_d = gain_stg_q;
      blank_d    = blank_q;
      if (frame_start) begin
         act_d.subsample    = reg_q[`SCU_IDX_SEQ_CTRL][`SCU_SEQ_SUBSAMPLE_BIT];
         act_d.binning      = reg_q[`SCU_IDX_SEQ_CTRL][`SCU_SEQ_BINNING_BIT];
         act_d.window       = reg_q[`SCU_IDX_WINDOW_SEL];
         act_d.dark_lines   = reg_q[`SCU_IDX_DARK_LINES];
         act_d.filler_lines = reg_q[`SCU_IDX_FILLER_LINES];
         exp_stg_d          = exp_pend;
         act_d.exposure     = exp_now ? exp_pend : exp_stg_q;
         gain_stg_d         = reg_q[`SCU_IDX_GAIN];
         act_d.gain         = gain_late ? gain_stg_q : reg_q[`SCU_IDX_GAIN];
         // geometry writes never enter this term
         blank_d = rolling & (lines_chg | (win_switch
                 & reg_q[`SCU_IDX_SYNC_CFG][`SCU_SYNC_BLANK_WIN_BIT]));
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         act_q      <= '0;
         exp_stg_q  <= '0;
         gain_stg_q <= `SCU_RESET_WORD;
         blank_q    <= 1'b0;
      end else if (clk_en) begin
         act_q      <= act_d;
         exp_stg_q  <= exp_stg_d;
         gain_stg_q <= gain_stg_d;
         blank_q    <= blank_d;
      end
   end

   assign spi_miso      = miso_q;
   assign spi_miso_oe   = oe_q;
   assign live_cfg      = reg_q;
   assign active_cfg    = act_q;
   assign send_training = blank_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic fs_en;
   assign fs_en = frame_start & clk_en;

   hold_mid_frame_a: assert property (@(posedge clock) disable iff (!rst_n)
      !fs_en |=> $stable(act_q)) else $error("active copy changed mid-frame");
   subsample_apply_a: assert property (@(posedge clock) disable iff (!rst_n)
      fs_en |=> act_q.subsample == $past(reg_q[`SCU_IDX_SEQ_CTRL][`SCU_SEQ_SUBSAMPLE_BIT]))
      else $error("subsample not taken at frame start");
   lines_blank_a: assert property (@(posedge clock) disable iff (!rst_n)
      fs_en && rolling && lines_chg |=> send_training ##1 (fs_en || send_training))
      else $error("line count change did not blank");
   global_no_blank_a: assert property (@(posedge clock) disable iff (!rst_n)
      fs_en && !rolling |=> !send_training) else $error("blank in global shutter");
   window_blank_a: assert property (@(posedge clock) disable iff (!rst_n)
      fs_en && rolling && win_switch && reg_q[`SCU_IDX_SYNC_CFG][`SCU_SYNC_BLANK_WIN_BIT]
      |=> send_training) else $error("window switch did not blank");
   resize_no_blank_a: assert property (@(posedge clock) disable iff (!rst_n)
      fs_en && !win_switch && !lines_chg |=> !send_training)
      else $error("blank without switch or line change");
   training_start_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(send_training) |-> $past(fs_en)) else $error("blank began mid-frame");
   gain_next_a: assert property (@(posedge clock) disable iff (!rst_n)
      fs_en && !gain_late |=> act_q.gain == $past(reg_q[`SCU_IDX_GAIN]))
      else $error("gain not taken at frame start");
   gain_late_a: assert property (@(posedge clock) disable iff (!rst_n)
      fs_en && gain_late |=> act_q.gain == $past(gain_stg_q))
      else $error("gain not delayed one frame");
   exposure_late_a: assert property (@(posedge clock) disable iff (!rst_n)
      fs_en && !exp_now |=> act_q.exposure == $past(exp_stg_q))
      else $error("exposure did not lag one frame");
   write_lands_a: assert property (@(posedge clock) disable iff (!rst_n)
      wr_q && wr_map[6] && clk_en |=> live_cfg[$past(wr_map[5:0])] == $past(sh_q[15:0]))
      else $error("register write lost");

endmodule // scu_cfg_update

/* sim/scu_spi_ctrl.sv */
// controller model that drives the serial configuration port
`timescale 1ns/100ps
module scu_spi_ctrl (
   // clock
   input  wire logic clock,
   // serial configuration port
   output      logic spi_sck,
   output      logic spi_cs_n,
   output      logic spi_mosi,
   input  wire logic spi_miso
);
   logic       seq_on;
   logic [5:0] seq_mode;

   initial begin
      spi_sck  = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      seq_on   = 1'b0;
      seq_mode = 6'h00;
   end

   // ------------------------------------------------------------
   // one 26-bit frame, msb first, mode 0
   // ------------------------------------------------------------
   task automatic xfer(input logic [8:0] addr, input logic wr_en, input logic [15:0] wdata,
                       input int half, output logic [15:0] rdata);
      logic [25:0] frame;
      logic        skip;
      int          i;
      frame = {addr, wr_en, wdata};
      rdata = 16'h0000;
      skip  = wr_en & seq_on & (addr inside {9'h020, 9'h028, 9'h030, [9'h040:9'h047], 9'h070});
      skip  = skip | (wr_en & seq_on & (addr == 9'h0c0) & (wdata[6:1] != seq_mode));
      skip  = skip | (wr_en & (addr > 9'h117));
      if (!skip) begin
         @(posedge clock);
         #1 spi_cs_n = 1'b0;
         for (i = 25; i >= 0; i--) begin
            spi_mosi = frame[i];
            repeat (half) @(posedge clock);
            #1;
            if (i < 16) rdata[i] = spi_miso;
            spi_sck = 1'b1;
            repeat (half) @(posedge clock);
            #1 spi_sck = 1'b0;
         end
         repeat (half) @(posedge clock);
         #1 spi_cs_n = 1'b1;
         // released line must not keep the last bit
         spi_mosi = ~spi_mosi;
         repeat (half) @(posedge clock);
         #1;
         if (wr_en && addr == 9'h0c0) begin
            seq_on   = wdata[0];
            seq_mode = wdata[6:1];
         end
      end
   endtask
endmodule // scu_spi_ctrl

/* sim/tb_sensor_config_update_policy.sv */
// self-checking bench for the frame-synchronised configuration store
`timescale 1ns/100ps
`include "scu_cfg_regs.svh"
module tb_sensor_config_update_policy;
   logic                               clock;
   logic                               resetn;
   logic                               clk_en;
   logic                               frame_start;
   logic                               spi_sck;
   logic                               spi_cs_n;
   logic                               spi_mosi;
   logic                               spi_miso;
   logic                               spi_miso_oe;
   scu_pkg::scu_word_t [`SCU_NREG-1:0] live_cfg;
   scu_pkg::scu_active_t               active_cfg;
   logic                               send_training;
   int                                 num_errors;
   int                                 checks_done;
   int                                 cycles;
   int                                 i;
   logic [15:0]                        rdata;
   logic                               oe_seen = 1'b0;
   logic [8:0] addrs [19] = '{9'h020, 9'h028, 9'h030, 9'h040, 9'h047, 9'h070, 9'h080, 9'h087,
                              9'h090, 9'h096, 9'h0c3, 9'h0c5, 9'h0c6, 9'h0c7, 9'h0cb, 9'h0cc,
                              9'h0ce, 9'h100, 9'h117};
   logic [5:0] idxs [19]  = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0a, 6'h0b, 6'h0c, 6'h13, 6'h14,
                              6'h1a, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h23, 6'h24, 6'h25, 6'h26,
                              6'h3d};

   scu_cfg_update scu_cfg_update_i (
      .clock(clock), .resetn(resetn), .clk_en(clk_en),
      .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .frame_start(frame_start), .live_cfg(live_cfg), .active_cfg(active_cfg),
      .send_training(send_training));

   scu_spi_ctrl scu_spi_ctrl_i (
      .clock(clock), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso));

   always #4 clock = ~clock;

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic test_done(input string name);
      $display("test %s done, mismatches so far %0d", name, num_errors);
   endtask

   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      logic [15:0] r;
      scu_spi_ctrl_i.xfer(a, 1'b1, d, 6, r);
   endtask

   task automatic rd(input logic [8:0] a, input int half, output logic [15:0] d);
      scu_spi_ctrl_i.xfer(a, 1'b0, 16'h0000, half, d);
   endtask

   task automatic pulse_frame(input logic en);
      @(posedge clock);
      #1 frame_start = 1'b1;
      clk_en = en;
      @(posedge clock);
      #1 frame_start = 1'b0;
      clk_en = 1'b1;
      repeat (2) @(posedge clock);
      #1;
   endtask

   task automatic train_is(input logic t);
      chk("send_training", {15'h0000, t}, {15'h0000, send_training});
   endtask

   always @(posedge clock) begin
      cycles++;
      if (spi_miso_oe === 1'b1) oe_seen = 1'b1;
      if (cycles == 40000) begin
         num_errors++;
         end_of_test;
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0; resetn = 1'b0; clk_en = 1'b1; frame_start = 1'b0;
      num_errors = 0; checks_done = 0; cycles = 0;
      repeat (12) @(posedge clock);
      #1 resetn = 1'b1;
      repeat (8) @(posedge clock);
      #1;
      for (i = 0; i < `SCU_NREG; i++) chk("live_cfg reset", 16'h0000, live_cfg[i]);
      chk("active gain reset", 16'h0000, active_cfg.gain);
      train_is(1'b0);
      test_done("reset");
      for (i = 0; i < 19; i++) begin
         wr(addrs[i], 16'h0a5c ^ {7'h00, addrs[i]});
         chk("live_cfg", 16'h0a5c ^ {7'h00, addrs[i]}, live_cfg[idxs[i]]);
         rd(addrs[i], (i % 2) ? 5 : 9, rdata);
         chk("read back", 16'h0a5c ^ {7'h00, addrs[i]}, rdata);
      end
      rd(9'h1ff, 6, rdata);
      chk("unmapped read", 16'h0000, rdata);
      chk("miso enable idle", 16'h0000, {15'h0000, spi_miso_oe});
      chk("miso enable seen", 16'h0001, {15'h0000, oe_seen});
      chk("window before frame", 16'h0000, active_cfg.window);
      test_done("register access");
      pulse_frame(1'b1);
      chk("window", 16'h0a9f, active_cfg.window);
      chk("dark lines", 16'h0a99, active_cfg.dark_lines);
      chk("filler lines", 16'h0a9a, active_cfg.filler_lines);
      chk("gain", 16'h0a90, active_cfg.gain);
      chk("exposure late", 16'h0000, active_cfg.exposure[0]);
      train_is(1'b0);
      pulse_frame(1'b1);
      chk("exposure", 16'h0a9b, active_cfg.exposure[0]);
      wr(9'h0c0, 16'h0180);
      wr(9'h0cc, 16'h1234);
      chk("subsample before frame", 16'h0000, {15'h0000, active_cfg.subsample});
      pulse_frame(1'b0);
      chk("gain held", 16'h0a90, active_cfg.gain);
      pulse_frame(1'b1);
      chk("gain", 16'h1234, active_cfg.gain);
      chk("subsample", 16'h0001, {15'h0000, active_cfg.subsample});
      chk("binning", 16'h0001, {15'h0000, active_cfg.binning});
      test_done("frame sync");
      wr(9'h0c0, 16'h0002);
      wr(9'h0c0, 16'h0003);
      for (i = 0; i < 2; i++) begin
         wr(i ? 9'h0c6 : 9'h0c5, 16'h0010);
         pulse_frame(1'b1);
         train_is(1'b1);
         pulse_frame(1'b1);
         train_is(1'b0);
      end
      chk("subsample off", 16'h0000, {15'h0000, active_cfg.subsample});
      wr(9'h0c3, 16'h0001);
      pulse_frame(1'b1);
      train_is(1'b0);
      wr(9'h0ce, 16'h0100);
      wr(9'h0c3, 16'h0002);
      pulse_frame(1'b1);
      train_is(1'b1);
      wr(9'h0c3, 16'h0002);
      wr(9'h100, 16'h0777);
      chk("geometry", 16'h0777, live_cfg[38]);
      wr(9'h080, 16'h0333);
      chk("black level", 16'h0333, live_cfg[12]);
      pulse_frame(1'b1);
      train_is(1'b0);
      test_done("blanking");
      wr(9'h0c0, 16'h0002);
      wr(9'h0c0, 16'h0410);
      wr(9'h0c0, 16'h0411);
      wr(9'h0c7, 16'h2000);
      pulse_frame(1'b1);
      chk("exposure immediate", 16'h2000, active_cfg.exposure[0]);
      wr(9'h0cc, 16'h0055);
      pulse_frame(1'b1);
      chk("gain aligned late", 16'h1234, active_cfg.gain);
      pulse_frame(1'b1);
      chk("gain aligned", 16'h0055, active_cfg.gain);
      test_done("exposure and gain");
      end_of_test;
   end
endmodule // tb_sensor_config_update_policy
